/* logic/gpp_pkg.sv */
// gpp_pkg: register map, pin config layout and pin routing constants
// for the eight-pin general purpose port; shared by all port logic.
package gpp_pkg;
  localparam int NPIN = 8;
  localparam int AW = 8;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  localparam logic [7:0] ADR_DIR = 8'h00;
  localparam logic [7:0] ADR_DIRSET = 8'h04;
  localparam logic [7:0] ADR_DIRCLR = 8'h08;
  localparam logic [7:0] ADR_DIRTGL = 8'h0C;
  localparam logic [7:0] ADR_OUT = 8'h10;
  localparam logic [7:0] ADR_OUTSET = 8'h14;
  localparam logic [7:0] ADR_OUTCLR = 8'h18;
  localparam logic [7:0] ADR_OUTTGL = 8'h1C;
  localparam logic [7:0] ADR_IN = 8'h20;
  localparam logic [7:0] ADR_FLAGS = 8'h24;
  localparam logic [7:0] ADR_MASK0 = 8'h28;
  localparam logic [7:0] ADR_MASK1 = 8'h2C;
  localparam logic [7:0] ADR_MPC = 8'h30;
  localparam logic [7:0] ADR_MULTI = 8'h34;
  localparam logic [7:0] ADR_OCFG = 8'h38;
  localparam logic [7:0] ADR_REMAP = 8'h3C;
  localparam logic [7:0] ADR_PCFG0 = 8'h40;
  localparam logic [7:0] ADR_PCFG_STEP = 8'h04;

  // output routing bits and remap bits
  localparam int OCFG_CLK = 0;
  localparam int OCFG_RTC = 1;
  localparam int OCFG_EVT = 2;
  localparam int RMP_USART = 0;
  localparam int RMP_SPI = 1;
  localparam int RMP_TMR = 2;

  localparam logic [2:0] PIN_CLKO = 3'h7;
  localparam logic [2:0] PIN_RTCO = 3'h6;
  localparam logic [2:0] PIN_EVO = 3'h2;
  localparam logic [2:0] PIN_USART = 3'h3;
  localparam logic [2:0] PIN_USART_ALT = 3'h7;
  localparam logic [2:0] PIN_SPI = 3'h5;
  localparam logic [2:0] PIN_SPI_ALT = 3'h1;
  localparam logic [2:0] PIN_TMR = 3'h0;
  localparam logic [2:0] PIN_TMR_ALT = 3'h4;

  typedef enum logic [2:0] {
    ISC_BOTH = 3'h0,
    ISC_RISE = 3'h1,
    ISC_FALL = 3'h2,
    ISC_LOW = 3'h3
  } gpp_isc_t;

  typedef enum logic [2:0] {
    OPC_TOTEM = 3'h0,
    OPC_KEEP = 3'h1,
    OPC_PDN = 3'h2,
    OPC_PUP = 3'h3,
    OPC_WOR = 3'h4,
    OPC_WAND = 3'h5,
    OPC_WORPD = 3'h6,
    OPC_WANDPU = 3'h7
  } gpp_opc_t;

  typedef struct packed {
    logic slew;
    logic inv;
    gpp_opc_t opc;
    gpp_isc_t isc;
  } gpp_pcfg_t;

  typedef struct packed {
    logic en;
    logic val;
  } gpp_alt_t;
endpackage : gpp_pkg

/* logic/gpp_sync2.sv */
// gpp_sync2: two flip-flop synchroniser, W bits wide.
// assumes each bit is an independent level; no bus coherence.
`timescale 1ns/1ps
`default_nettype none
module gpp_sync2 #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : gpp_sync2
`default_nettype wire

/* logic/gpp_port.sv */
// gpp_port: eight-pin general purpose port behind an AXI4-Lite slave.
// assumes pads resolve pin_o/pin_oe_n/pulls; peripherals on clk domain.
`timescale 1ns/1ps
`default_nettype none
module gpp_port (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_n,
  output logic [7:0] pull_up,
  output logic [7:0] pull_dn,
  output logic [7:0] slew_lim,
  input wire logic port_clk_en,
  input wire logic rtc_clk_i,
  input wire logic evt_i,
  input wire gpp_pkg::gpp_alt_t alt_usart,
  input wire gpp_pkg::gpp_alt_t alt_spi,
  input wire gpp_pkg::gpp_alt_t alt_tmr,
  output logic irq0,
  output logic irq1,
  output logic [7:0] evt_o,
  output logic wake_o
);
  localparam int N = gpp_pkg::NPIN;

  logic aw_free_q, w_free_q, ar_free_q, bvalid_q, rvalid_q;
  logic [7:0] wa_q, wd_q;
  logic ws_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] dir_q, out_q, mask0_q, mask1_q, flag_q, mpc_q;
  logic [7:0] ocfg_q, remap_q, prev_q, keep_q, evt_q;
  gpp_pkg::gpp_pcfg_t cfg_q [N];
  logic [7:0] pin_s, pin_v, det, clr;
  logic [7:0] drv, val, pu, pd;
  logic [7:0] pin_o_q, oe_n_q, pu_q, pd_q, slew_q;
  logic irq0_q, irq1_q, clkdiv_q;
  logic irq0_d;
  logic rtc_s;
  logic wr_go, we;
  logic [7:0] rd_d;
  logic rok_d;

  assign awready = aw_free_q;
  assign wready = w_free_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = ar_free_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign pin_o = pin_o_q;
  assign pin_oe_n = oe_n_q;
  assign pull_up = pu_q;
  assign pull_dn = pd_q;
  assign slew_lim = slew_q;
  assign irq0 = irq0_q;
  assign irq1 = irq1_q;
  assign evt_o = evt_q;

  // both halves of a write held and no response pending
  assign wr_go = !aw_free_q && !w_free_q && !bvalid_q;
  assign we = wr_go && ws_q;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a <= gpp_pkg::ADR_REMAP && a[1:0] == 2'h0) ||
      (a >= gpp_pkg::ADR_PCFG0 && a[1:0] == 2'h0 &&
       a < gpp_pkg::ADR_PCFG0 + 8'(N) * gpp_pkg::ADR_PCFG_STEP);
  endfunction : addr_ok

  // write channel: address and data taken in either order
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_free_q <= 1'b1;
      w_free_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= gpp_pkg::RESP_OK;
      wa_q <= gpp_pkg::RST_BYTE;
      wd_q <= gpp_pkg::RST_BYTE;
      ws_q <= 1'b0;
    end else begin
      if (awvalid && aw_free_q) begin
        aw_free_q <= 1'b0;
        wa_q <= awaddr;
      end
      if (wvalid && w_free_q) begin
        w_free_q <= 1'b0;
        wd_q <= wdata[7:0];
        ws_q <= wstrb[0];
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= addr_ok(wa_q) ? gpp_pkg::RESP_OK : gpp_pkg::RESP_ERR;
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        aw_free_q <= 1'b1;
        w_free_q <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_d = gpp_pkg::RST_BYTE;
    rok_d = 1'b1;
    case (araddr)
      gpp_pkg::ADR_DIR: rd_d = dir_q;
      gpp_pkg::ADR_DIRSET: rd_d = dir_q;
      gpp_pkg::ADR_DIRCLR: rd_d = dir_q;
      gpp_pkg::ADR_DIRTGL: rd_d = dir_q;
      gpp_pkg::ADR_OUT: rd_d = out_q;
      gpp_pkg::ADR_OUTSET: rd_d = out_q;
      gpp_pkg::ADR_OUTCLR: rd_d = out_q;
      gpp_pkg::ADR_OUTTGL: rd_d = out_q;
      gpp_pkg::ADR_IN: rd_d = pin_v;
      gpp_pkg::ADR_FLAGS: rd_d = flag_q;
      gpp_pkg::ADR_MASK0: rd_d = mask0_q;
      gpp_pkg::ADR_MASK1: rd_d = mask1_q;
      gpp_pkg::ADR_MPC: rd_d = mpc_q;
      gpp_pkg::ADR_MULTI: rd_d = gpp_pkg::RST_BYTE;
      gpp_pkg::ADR_OCFG: rd_d = ocfg_q;
      gpp_pkg::ADR_REMAP: rd_d = remap_q;
      default: begin
        rok_d = addr_ok(araddr);
        for (int i = 0; i < N; i++) begin
          if (araddr == gpp_pkg::ADR_PCFG0 +
              8'(i) * gpp_pkg::ADR_PCFG_STEP) begin
            rd_d = cfg_q[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ar_free_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= gpp_pkg::RESP_OK;
    end else if (arvalid && ar_free_q) begin
      ar_free_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_d};
      rresp_q <= rok_d ? gpp_pkg::RESP_OK : gpp_pkg::RESP_ERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      ar_free_q <= 1'b1;
    end
  end

  // set/clear/toggle aliases touch only the bits written as one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dir_q <= gpp_pkg::RST_BYTE;
      out_q <= gpp_pkg::RST_BYTE;
    end else if (we) begin
      case (wa_q)
        gpp_pkg::ADR_DIR: dir_q <= wd_q;
        gpp_pkg::ADR_DIRSET: dir_q <= dir_q | wd_q;
        gpp_pkg::ADR_DIRCLR: dir_q <= dir_q & ~wd_q;
        gpp_pkg::ADR_DIRTGL: dir_q <= dir_q ^ wd_q;
        gpp_pkg::ADR_OUT: out_q <= wd_q;
        gpp_pkg::ADR_OUTSET: out_q <= out_q | wd_q;
        gpp_pkg::ADR_OUTCLR: out_q <= out_q & ~wd_q;
        gpp_pkg::ADR_OUTTGL: out_q <= out_q ^ wd_q;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask0_q <= gpp_pkg::RST_BYTE;
      mask1_q <= gpp_pkg::RST_BYTE;
      mpc_q <= gpp_pkg::RST_BYTE;
      ocfg_q <= gpp_pkg::RST_BYTE;
      remap_q <= gpp_pkg::RST_BYTE;
    end else if (we) begin
      case (wa_q)
        gpp_pkg::ADR_MASK0: mask0_q <= wd_q;
        gpp_pkg::ADR_MASK1: mask1_q <= wd_q;
        gpp_pkg::ADR_MPC: mpc_q <= wd_q;
        gpp_pkg::ADR_OCFG: ocfg_q <= wd_q;
        gpp_pkg::ADR_REMAP: remap_q <= wd_q;
        default: ;
      endcase
    end
  end

  // per-pin config, or many pins at once through the multi register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < N; i++) begin
        cfg_q[i] <= gpp_pkg::RST_BYTE;
      end
    end else if (we) begin
      for (int i = 0; i < N; i++) begin
        if (wa_q == gpp_pkg::ADR_PCFG0 + 8'(i) * gpp_pkg::ADR_PCFG_STEP) begin
          cfg_q[i] <= wd_q;
        end else if (wa_q == gpp_pkg::ADR_MULTI && mpc_q[i]) begin
          cfg_q[i] <= wd_q;
        end
      end
    end
  end

  gpp_sync2 #(.W(N)) u_pin_sync (
    .clk(clk),
    .rstn(rstn),
    .d(pin_i),
    .q(pin_s)
  );

  gpp_sync2 #(.W(1)) u_rtc_sync (
    .clk(clk),
    .rstn(rstn),
    .d(rtc_clk_i),
    .q(rtc_s)
  );

  always_comb begin
    for (int i = 0; i < N; i++) begin
      pin_v[i] = pin_s[i] ^ cfg_q[i].inv;
      case (cfg_q[i].isc)
        gpp_pkg::ISC_BOTH: det[i] = pin_v[i] ^ prev_q[i];
        gpp_pkg::ISC_RISE: det[i] = pin_v[i] & ~prev_q[i];
        gpp_pkg::ISC_FALL: det[i] = ~pin_v[i] & prev_q[i];
        gpp_pkg::ISC_LOW: det[i] = ~pin_v[i];
        default: det[i] = 1'b0;
      endcase
    end
  end

  assign clr = (we && wa_q == gpp_pkg::ADR_FLAGS) ? wd_q : 8'h00;
  assign irq0_d = |(flag_q & mask0_q);

  // a detection in the clearing cycle keeps its flag set
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= gpp_pkg::RST_BYTE;
      prev_q <= gpp_pkg::RST_BYTE;
      evt_q <= gpp_pkg::RST_BYTE;
      irq0_q <= 1'b0;
      irq1_q <= 1'b0;
    end else begin
      if (port_clk_en) begin
        prev_q <= pin_v;
      end
      evt_q <= port_clk_en ? det : 8'h00;
      flag_q <= (flag_q & ~clr) | (port_clk_en ? det : 8'h00);
      irq0_q <= irq0_d;
      irq1_q <= |(flag_q & mask1_q);
    end
  end

  // clockless path: prev_q is frozen while the port clock is off, so a
  // raw pin differing from it (or a low level) wakes with no edge needed
  always_comb begin
    wake_o = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (!port_clk_en && (mask0_q[i] || mask1_q[i]) &&
          (cfg_q[i].isc == gpp_pkg::ISC_LOW ?
           !(pin_i[i] ^ cfg_q[i].inv) :
           ((pin_i[i] ^ cfg_q[i].inv) != prev_q[i]))) begin
        wake_o = 1'b1;
      end
    end
  end

  // peripheral clock out is clk/2: a pin cannot carry clk from a flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clkdiv_q <= 1'b0;
    end else begin
      clkdiv_q <= ~clkdiv_q;
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      logic d;
      logic v;
      d = dir_q[i];
      v = out_q[i] ^ cfg_q[i].inv;
      if (ocfg_q[gpp_pkg::OCFG_CLK] && 3'(i) == gpp_pkg::PIN_CLKO) begin
        d = 1'b1;
        v = clkdiv_q;
      end
      if (ocfg_q[gpp_pkg::OCFG_RTC] && 3'(i) == gpp_pkg::PIN_RTCO) begin
        d = 1'b1;
        v = rtc_s;
      end
      if (ocfg_q[gpp_pkg::OCFG_EVT] && 3'(i) == gpp_pkg::PIN_EVO) begin
        d = 1'b1;
        v = evt_i;
      end
      if (alt_tmr.en && 3'(i) == (remap_q[gpp_pkg::RMP_TMR] ?
          gpp_pkg::PIN_TMR_ALT : gpp_pkg::PIN_TMR)) begin
        d = 1'b1;
        v = alt_tmr.val;
      end
      if (alt_spi.en && 3'(i) == (remap_q[gpp_pkg::RMP_SPI] ?
          gpp_pkg::PIN_SPI_ALT : gpp_pkg::PIN_SPI)) begin
        d = 1'b1;
        v = alt_spi.val;
      end
      if (alt_usart.en && 3'(i) == (remap_q[gpp_pkg::RMP_USART] ?
          gpp_pkg::PIN_USART_ALT : gpp_pkg::PIN_USART)) begin
        d = 1'b1;
        v = alt_usart.val;
      end
      val[i] = v;
      case (cfg_q[i].opc)
        gpp_pkg::OPC_WOR, gpp_pkg::OPC_WORPD: drv[i] = d & v;
        gpp_pkg::OPC_WAND, gpp_pkg::OPC_WANDPU: drv[i] = d & ~v;
        default: drv[i] = d;
      endcase
      case (cfg_q[i].opc)
        gpp_pkg::OPC_PUP, gpp_pkg::OPC_WANDPU: begin
          pu[i] = ~drv[i];
          pd[i] = 1'b0;
        end
        gpp_pkg::OPC_PDN, gpp_pkg::OPC_WORPD: begin
          pu[i] = 1'b0;
          pd[i] = ~drv[i];
        end
        gpp_pkg::OPC_KEEP: begin
          pu[i] = ~drv[i] & keep_q[i];
          pd[i] = ~drv[i] & ~keep_q[i];
        end
        default: begin
          pu[i] = 1'b0;
          pd[i] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_o_q <= gpp_pkg::RST_BYTE;
      oe_n_q <= 8'hFF;
      pu_q <= gpp_pkg::RST_BYTE;
      pd_q <= gpp_pkg::RST_BYTE;
      slew_q <= gpp_pkg::RST_BYTE;
      keep_q <= gpp_pkg::RST_BYTE;
    end else begin
      pin_o_q <= val;
      oe_n_q <= ~drv;
      pu_q <= pu;
      pd_q <= pd;
      keep_q <= pin_s;
      for (int i = 0; i < N; i++) begin
        slew_q[i] <= cfg_q[i].slew;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_wr_held;
    !aw_free_q && !w_free_q && !bvalid_q;
  endsequence

  a_write_answer: assert property (s_wr_held |=> bvalid_q)
    else $error("write not answered");
  a_flag_sticky: assert property (flag_q[0] && !clr[0] |=> flag_q[0])
    else $error("flag lost without clear");
  a_rise_flags: assert property (port_clk_en && pin_v[1] && !prev_q[1] &&
    cfg_q[1].isc == gpp_pkg::ISC_RISE |=> flag_q[1] && evt_q[1])
    else $error("rising edge missed");
  a_no_clock_evt: assert property (!port_clk_en |=> evt_q == 8'h00)
    else $error("event without port clock");
  a_pin_sync: assert property (pin_s[0] == $past(pin_i[0], 2))
    else $error("synchroniser depth wrong");
  a_irq_mask: assert property (irq0_q == $past(irq0_d))
    else $error("irq0 disagrees with mask");
  a_dir_set: assert property (we && wa_q == gpp_pkg::ADR_DIRSET
    |=> dir_q == ($past(dir_q) | $past(wd_q)))
    else $error("dirset disturbed other pins");
  a_multi_cfg: assert property (we && wa_q == gpp_pkg::ADR_MULTI &&
    mpc_q[1] |=> cfg_q[1] == $past(wd_q))
    else $error("multi-pin write missed");
  a_wand_low: assert property (cfg_q[5].opc == gpp_pkg::OPC_WAND &&
    $stable(cfg_q[5]) && !oe_n_q[5] |-> !pin_o_q[5])
    else $error("wired-and drove high");
  a_alt_ovr: assert property (alt_usart.en && !remap_q[gpp_pkg::RMP_USART]
    && cfg_q[3].opc == gpp_pkg::OPC_TOTEM
    |=> !oe_n_q[3] && pin_o_q[3] == $past(alt_usart.val))
    else $error("usart override missing");
endmodule : gpp_port
`default_nettype wire

/* sim/gpp_pins_model.sv */
// gpp_pins_model: external circuitry standing on the eight port pins.
// assumes pulls are weak and lose to any strong driver on the wire.
`timescale 1ns/1ps
`default_nettype none
module gpp_pins_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pull_up,
  input wire logic [7:0] pull_dn,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_i
);
  logic [7:0] last_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_q <= 8'h00;
    end else begin
      last_q <= pin_i;
    end
  end

  // a floating pin toggles, so a stale level never passes for a held one
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_i[i] = !pin_oe_n[i] ? pin_o[i] : ext_en[i] ? ext_val[i] :
                 pull_up[i] ? 1'b1 : pull_dn[i] ? 1'b0 : ~last_q[i];
    end
  end
endmodule : gpp_pins_model
`default_nettype wire

/* sim/gpp_port_bench.sv */
// gpp_port_bench: self-checking bench for the eight-pin port.
// assumes gpp_pins_model on the pins and one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module gpp_port_bench;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr, pin_i, pin_o, pin_oe_n, pull_up, pull_dn;
  logic [7:0] slew_lim, evt_o, ext_en, ext_val, evt_seen;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, port_clk_en, rtc_clk_i;
  logic evt_i, irq0, irq1, wake_o, clk_seen;
  gpp_pkg::gpp_alt_t alt_usart, alt_spi, alt_tmr;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  gpp_port dut_u (.clk, .rstn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .pin_i, .pin_o, .pin_oe_n,
    .pull_up, .pull_dn, .slew_lim, .port_clk_en, .rtc_clk_i, .evt_i,
    .alt_usart, .alt_spi, .alt_tmr, .irq0, .irq1, .evt_o, .wake_o);
  gpp_pins_model pins_u (.clk, .rstn, .pin_o, .pin_oe_n, .pull_up,
    .pull_dn, .ext_en, .ext_val, .pin_i);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic summarize();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // one write at a time; each channel released at its own handshake
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    check("bresp", gpp_pkg::RESP_OK, bresp);
  endtask : wr

  task automatic chk_rd(input string n, input logic [7:0] a,
    input logic [31:0] e, input logic [1:0] er = gpp_pkg::RESP_OK);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    check(n, e, rdata);
    check("rresp", er, rresp);
  endtask : chk_rd

  // events are pulses, so they are gathered for a later compare
  always @(posedge clk) begin
    evt_seen <= rstn ? (evt_seen | evt_o) : 8'h00;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    port_clk_en = 1'b1;
    rtc_clk_i = 1'b0;
    evt_i = 1'b0;
    alt_usart = '{en: 1'b0, val: 1'b0};
    alt_spi = '{en: 1'b0, val: 1'b0};
    alt_tmr = '{en: 1'b0, val: 1'b0};
    ext_en = 8'hFF;
    ext_val = 8'h08;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    check("pin_oe_n", 8'hFF, pin_oe_n);
    chk_rd("DIR", gpp_pkg::ADR_DIR, 0);
    // sensing: every mode on pins 0..3, pins 4..7 set to no sensing
    wr(gpp_pkg::ADR_MPC, 8'hFF);
    wr(gpp_pkg::ADR_MULTI, 8'h04);
    for (int k = 0; k < 4; k++) begin
      wr(gpp_pkg::ADR_PCFG0 + 8'(k) * gpp_pkg::ADR_PCFG_STEP, 8'(k));
    end
    chk_rd("PCFG5", gpp_pkg::ADR_PCFG0 + 8'h14, 8'h04);
    chk_rd("MULTI", gpp_pkg::ADR_MULTI, 0);
    wr(gpp_pkg::ADR_FLAGS, 8'hFF);
    ext_val <= 8'h07;
    cyc(2);
    check("evt_early", 3'h0, evt_seen[2:0]);
    cyc(4);
    chk_rd("FLAGS", gpp_pkg::ADR_FLAGS, 8'h0B);
    wr(gpp_pkg::ADR_FLAGS, 8'h0B);
    ext_val <= 8'h00;
    cyc(6);
    chk_rd("FLAGS", gpp_pkg::ADR_FLAGS, 8'h0D);
    check("evt_o", 8'h0F, evt_seen);
    // two interrupts, each with its own pin mask
    wr(gpp_pkg::ADR_MASK0, 8'h01);
    wr(gpp_pkg::ADR_MASK1, 8'h02);
    cyc(2);
    check("irq", 2'b10, {irq0, irq1});
    wr(gpp_pkg::ADR_MASK1, 8'h04);
    cyc(2);
    check("irq1", 1'b1, irq1);
    wr(gpp_pkg::ADR_FLAGS, 8'h05);
    cyc(2);
    check("irq", 2'b00, {irq0, irq1});
    // clock off: no flags, but a masked pin change still wakes
    port_clk_en <= 1'b0;
    cyc(2);
    check("wake_o", 1'b0, wake_o);
    ext_val <= 8'h01;
    cyc(2);
    check("wake_o", 1'b1, wake_o);
    chk_rd("FLAGS", gpp_pkg::ADR_FLAGS, 8'h08);
    ext_val <= 8'h00;
    cyc(2);
    check("wake_o", 1'b0, wake_o);
    port_clk_en <= 1'b1;
    cyc(2);
    wr(gpp_pkg::ADR_PCFG0, 8'h40);
    cyc(5);
    chk_rd("FLAGS", gpp_pkg::ADR_FLAGS, 8'h09);
    chk_rd("IN", gpp_pkg::ADR_IN, 8'h01);
    wr(gpp_pkg::ADR_PCFG0, 8'h00);
    // direction and drive through set, clear and toggle aliases
    wr(gpp_pkg::ADR_DIR, 8'h0F);
    wr(gpp_pkg::ADR_DIRSET, 8'h30);
    chk_rd("DIR", gpp_pkg::ADR_DIR, 8'h3F);
    wr(gpp_pkg::ADR_DIRCLR, 8'h01);
    chk_rd("DIRSET", gpp_pkg::ADR_DIRSET, 8'h3E);
    wr(gpp_pkg::ADR_DIRTGL, 8'h81);
    chk_rd("DIR", gpp_pkg::ADR_DIR, 8'hBF);
    cyc(2);
    check("pin_oe_n", 8'h40, pin_oe_n);
    wr(gpp_pkg::ADR_OUT, 8'h0F);
    wr(gpp_pkg::ADR_OUTSET, 8'hF0);
    wr(gpp_pkg::ADR_OUTCLR, 8'h03);
    wr(gpp_pkg::ADR_OUTTGL, 8'h11);
    chk_rd("OUT", gpp_pkg::ADR_OUT, 8'hED);
    cyc(2);
    check("pin_o", 8'hAD, pin_o & 8'hBF);
    // driver kinds: wired-AND, pull-up with slew limit, bus-keeper
    wr(gpp_pkg::ADR_PCFG0 + 8'h14, 8'h28);
    cyc(2);
    check("wand_high", 1'b1, pin_oe_n[5]);
    wr(gpp_pkg::ADR_OUTCLR, 8'h20);
    cyc(2);
    check("wand_low", 2'b00, {pin_oe_n[5], pin_o[5]});
    wr(gpp_pkg::ADR_PCFG0 + 8'h18, 8'h98);
    cyc(2);
    check("slew_pull", 2'b11, {slew_lim[6], pull_up[6]});
    wr(gpp_pkg::ADR_PCFG0 + 8'h18, 8'h08);
    cyc(4);
    check("keep_low", 2'b01, {pull_up[6], pull_dn[6]});
    ext_val <= 8'h40;
    // two sync stages, keeper flop, then the pull flop
    cyc(5);
    check("keep_high", 2'b10, {pull_up[6], pull_dn[6]});
    ext_en <= 8'hBF;
    cyc(6);
    check("keep_hold", 2'b10, {pull_up[6], pull_dn[6]});
    // peripheral overrides, remap and event routing
    alt_usart <= '{en: 1'b1, val: 1'b0};
    cyc(2);
    check("usart_pin", 2'b00, {pin_oe_n[3], pin_o[3]});
    wr(gpp_pkg::ADR_REMAP, 8'h01);
    cyc(2);
    check("usart_alt", 3'h1, {pin_oe_n[7], pin_o[7], pin_o[3]});
    wr(gpp_pkg::ADR_OCFG, 8'h04);
    cyc(2);
    check("evt_pin", 1'b0, pin_o[2]);
    evt_i <= 1'b1;
    wr(gpp_pkg::ADR_OCFG, 8'h06);
    cyc(2);
    check("evt_rtc", 2'b10, {pin_o[2], pin_o[6]});
    rtc_clk_i <= 1'b1;
    cyc(4);
    check("rtc_pin", 1'b1, pin_o[6]);
    alt_spi <= '{en: 1'b1, val: 1'b1};
    alt_tmr <= '{en: 1'b1, val: 1'b0};
    wr(gpp_pkg::ADR_REMAP, 8'h03);
    cyc(2);
    check("spi_tmr", 2'b10, {pin_o[1], pin_o[0]});
    alt_tmr <= '{en: 1'b1, val: 1'b1};
    wr(gpp_pkg::ADR_REMAP, 8'h07);
    cyc(2);
    check("tmr_alt", 1'b1, pin_o[4]);
    alt_usart <= '{en: 1'b0, val: 1'b0};
    wr(gpp_pkg::ADR_OCFG, 8'h07);
    cyc(2);
    clk_seen = pin_o[7];
    cyc(1);
    check("clk_out", !clk_seen, pin_o[7]);
    chk_rd("unmapped", 8'h80, 0, gpp_pkg::RESP_ERR);
    summarize();
  end
endmodule : gpp_port_bench
`default_nettype wire
